// *** design/aor_defines.vh ***
// constants for the auto-negotiation ability override register bank
`ifndef AOR_DEFINES_VH
`define AOR_DEFINES_VH
`define AOR_ADDR_W          12
`define AOR_DATA_W          32
`define AOR_PORT_MSB        11
`define AOR_PORT_LSB        8
`define AOR_OFS_MSB         7
`define AOR_OFS_LSB         0
`define AOR_PORT_W          4
`define AOR_OFS_W           8
`define AOR_OVR_OFS         8'hcc
`define AOR_LANE_OFS        8'hd0
`define AOR_LANE_W          3
`define AOR_LANE_MAX        3'h7
`define AOR_LANE_ZERO       3'h0
`define AOR_BIT_LLFEC_REQ   3
`define AOR_BIT_LLFEC_50    4
`define AOR_BIT_LLFEC_100   5
`define AOR_BIT_LLFEC_200   6
`define AOR_BIT_RSFEC_ABL   8
`define AOR_BIT_FCFEC_ABL   9
`define AOR_BIT_RSFEC_REQ   10
`define AOR_BIT_FCFEC_REQ   11
`define AOR_IEEE_LO_LSB     12
`define AOR_IEEE_LO_MSB     18
`define AOR_IEEE_HI_LSB     19
`define AOR_IEEE_HI_MSB     23
`define AOR_CONS_LSB        24
`define AOR_CONS_MSB        28
`define AOR_BIT_IEEE_400    29
`define AOR_OVR_MASK        32'h3ffffe78
`define AOR_ZERO32          32'h00000000
`endif

// *** design/aor_lane_cfg.v ***
// build-time auto-negotiation lane selection, one shared by all ports
`timescale 1ns/1ps
`include "aor_defines.vh"
module aor_lane_cfg #(
    parameter [2:0] LANE_SEL  = 3'h0,
    parameter [3:0] NUM_LANES = 4'h1,
    parameter       DYN_ANLT  = 0
) (
    // legal lane out
    output wire [`AOR_LANE_W-1:0] autoneg_lane_select_out
);
    // lane beyond lane count, or dynamic multi-lane nonzero, falls back to lane 0
    wire single    = (NUM_LANES <= 4'h1);                       // R3
    wire in_range  = ({1'b0, LANE_SEL} < NUM_LANES);            // R1
    wire dyn_block = (DYN_ANLT != 0) && !single;                // R2
    assign autoneg_lane_select_out = (single || !in_range || dyn_block) ?
                                     `AOR_LANE_ZERO : LANE_SEL; // R1 R2 R3
endmodule // aor_lane_cfg

// *** design/aor_override_regs.v ***
// ability override register bank on the configuration bus
// What this block does
// R1: one lane select for all ports is build-time, 0 to 7, default 0, below lane count.
// R2: with dynamic reconfiguration, multi-lane ports use lane 0 only.
// R3: single-lane ports have no lane choice; their lane is lane 0.
// R4: offset 0xcc bit 3 holds low-latency FEC request override.
// R5: bits 4,5,6 hold low-latency FEC abilities for 50G, 100G, 200G.
// R6: bit 8, the RS-FEC ability override, is masked off; it reads zero and ignores writes.
// R7: bit 9 holds the Firecode FEC ability override.
// R8: bit 10 holds the RS-FEC request override.
// R9: bit 11 holds the Firecode FEC request override.
// R10: bits 12..18 advertise seven IEEE abilities, 10G KR up to 25G KR/CR.
// R11: bits 19..23 more IEEE abilities; bit 29 is 400G KR4/CR4.
// R12: bits 24..28 advertise five consortium abilities.
// R13: reset loads build-time values; unassigned bits read zero, ignore writes.
// R14: word-addressed 32-bit bus, byte offsets over four, byte strobes per byte.
// R15: address bits 11:8 are port, bits 7:0 the register offset.
// R16: host holds a request until stall is low.
// R17: each accepted read returns data with a one-cycle valid pulse.
`timescale 1ns/1ps
`include "aor_defines.vh"
module aor_override_regs #(
    parameter [3:0]  NUM_PORTS  = 4'h4,
    parameter [31:0] OVR_INIT   = 32'h00000000,
    parameter [2:0]  LANE_SEL   = 3'h0,
    parameter [3:0]  NUM_LANES  = 4'h4,
    parameter        DYN_ANLT   = 0
) (
    // clock and reset
    input  wire                    ref_clk_in,
    input  wire                    rst_in,
    // configuration bus
    input  wire [`AOR_ADDR_W-1:0]  cfg_bus_address_in,
    input  wire                    cfg_bus_read_in,
    input  wire                    cfg_bus_write_in,
    input  wire [3:0]              cfg_bus_byte_strobes_in,
    input  wire [`AOR_DATA_W-1:0]  cfg_bus_write_data_in,
    output reg  [`AOR_DATA_W-1:0]  cfg_bus_read_data_out,
    output reg                     cfg_bus_read_valid_out,
    output wire                    cfg_bus_stall_out,
    // advertisement outputs per port, packed, and one lane select for all ports
    output wire [`AOR_DATA_W*16-1:0] ability_override_out,
    output wire [`AOR_LANE_W-1:0]  autoneg_lane_select_out
);
    // reset image keeps only assigned bits
    localparam [31:0] INIT_MASKED = OVR_INIT & `AOR_OVR_MASK; // R13

    // address split into port and byte offset
    wire [`AOR_PORT_W-1:0] port = cfg_bus_address_in[`AOR_PORT_MSB:`AOR_PORT_LSB]; // R15
    wire [`AOR_OFS_W-1:0]  ofs  = cfg_bus_address_in[`AOR_OFS_MSB:`AOR_OFS_LSB];   // R15
    wire port_ok = (port < NUM_PORTS);

    // one accepted access per request; stall drops the cycle it is taken
    reg busy;
    assign cfg_bus_stall_out = (cfg_bus_read_in | cfg_bus_write_in) & ~busy; // R16
    wire take_wr = cfg_bus_write_in & busy;
    wire take_rd = cfg_bus_read_in & busy;

    // byte strobe mask
    wire [31:0] be_mask = {{8{cfg_bus_byte_strobes_in[3]}}, {8{cfg_bus_byte_strobes_in[2]}},
                           {8{cfg_bus_byte_strobes_in[1]}}, {8{cfg_bus_byte_strobes_in[0]}}}; // R14

    // request phase: one stall cycle then acceptance
    always @(posedge ref_clk_in)
    begin
        if (rst_in)
            busy <= 1'b0;
        else if ((cfg_bus_read_in | cfg_bus_write_in) & ~busy)
            busy <= 1'b1;
        else
            busy <= 1'b0;
    end

    // override register per port, each owned by its own loop entry
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1)
        begin : g_port
            reg  [31:0] ovr;
            wire        hit = take_wr && port_ok && (port == g) && (ofs == `AOR_OVR_OFS);
            always @(posedge ref_clk_in)
            begin
                if (rst_in)
                    ovr <= INIT_MASKED; // R4 R5 R6 R7 R8 R9 R10 R11 R12 R13
                else if (hit)
                    ovr <= ((ovr & ~be_mask) | (cfg_bus_write_data_in & be_mask))
                           & `AOR_OVR_MASK; // R13 R14
            end
            assign ability_override_out[g*32+31:g*32] = ovr;
        end
    endgenerate

    // build-time lane choice
    aor_lane_cfg #(
        .LANE_SEL  (LANE_SEL),
        .NUM_LANES (NUM_LANES),
        .DYN_ANLT  (DYN_ANLT)
    ) u_lane (
        .autoneg_lane_select_out (autoneg_lane_select_out)
    );

    // read data and single-cycle valid; unmapped offsets read zero
    always @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            cfg_bus_read_data_out  <= `AOR_ZERO32;
            cfg_bus_read_valid_out <= 1'b0;
        end
        else
        begin
            cfg_bus_read_valid_out <= take_rd; // R17
            if (take_rd)
            begin
                if (port_ok && ofs == `AOR_OVR_OFS)
                    cfg_bus_read_data_out <= ability_override_out[{port, 5'h00} +: 32];
                else if (port_ok && ofs == `AOR_LANE_OFS)
                    cfg_bus_read_data_out <= {29'h0, autoneg_lane_select_out}; // R1
                else
                    cfg_bus_read_data_out <= `AOR_ZERO32;
            end
        end
    end
endmodule // aor_override_regs

// *** dv/aor_checker.sv ***
// port assertions for the override bank
`timescale 1ns/1ps
module aor_checker (
    input wire         ref_clk_in, rst_in, cfg_bus_read_in, cfg_bus_write_in,
    input wire         cfg_bus_stall_out, cfg_bus_read_valid_out,
    input wire [511:0] ability_override_out
);
    // short aliases
    wire rd = cfg_bus_read_in, wr = cfg_bus_write_in, st = cfg_bus_stall_out;
    wire vl = cfg_bus_read_valid_out, tk = rd && !st;
    wire [31:0] ov = ability_override_out[31:0];
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    AST_PULSE: assert property (vl |=> !vl) else $error("long valid");
    AST_ANSWER: assert property (tk |=> vl) else $error("no answer");
    AST_CAUSE: assert property ($rose(vl) |-> $past(tk)) else $error("stray valid");
    AST_HOLD: assert property ($rose(rd || wr) |-> st) else $error("no stall");
    AST_BRIEF: assert property (st |=> !st) else $error("stall stuck");
    AST_IDLE: assert property (!rd && !wr |-> !st) else $error("idle stall");
    AST_RSVD: assert property ((ov & 32'hc0000187) == 32'h0) else $error("spare bit");
    AST_KEEP: assert property (!wr |=> $stable(ov)) else $error("lost value");
endmodule // aor_checker
bind aor_override_regs aor_checker u_chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .cfg_bus_read_in(cfg_bus_read_in), .cfg_bus_write_in(cfg_bus_write_in),
    .cfg_bus_stall_out(cfg_bus_stall_out), .cfg_bus_read_valid_out(cfg_bus_read_valid_out),
    .ability_override_out(ability_override_out));

// *** dv/aor_host.sv ***
// host model on the configuration bus
`timescale 1ns/1ps
module aor_host (
    input  wire        c_in, s_in, v_in,
    input  wire [31:0] q_in,
    output reg  [11:0] a_out = 12'hfff,
    output reg         rd_out = 1'b0, wr_out = 1'b0,
    output reg  [3:0]  b_out = 4'h0,
    output reg  [31:0] d_out = 32'h0
);
    // one access held two cycles, failing the bench if stall is still high, junk on the released bus
    task acc(input w, input [11:0] a, input [3:0] b, input [31:0] d, output [31:0] q);
        q = 32'hx;
        @(posedge c_in) #1 {rd_out, wr_out, a_out, b_out, d_out} = {!w, w, a, b, d};
        repeat (2) @(negedge c_in);
        if (s_in) aor_override_regs_bench.wrap_up(1);
        @(posedge c_in) #1 {rd_out, wr_out, a_out, d_out} = {2'h0, ~a, ~d};
        @(negedge c_in) if (v_in) q = q_in;
    endtask
endmodule // aor_host

// *** dv/aor_override_regs_bench.sv ***
// self-checking bench for the override bank
`timescale 1ns/1ps
module aor_override_regs_bench;
    reg          ref_clk_in = 1'b0, rst_in = 1'b1;
    reg  [31:0]  r;
    wire         rd, wr, st, vl;
    wire [2:0]   ln;
    wire [3:0]   b;
    wire [11:0]  a;
    wire [31:0]  d, q;
    wire [511:0] ov;
    integer      error_cnt = 0, tests_run = 0, i;
    initial forever #50 ref_clk_in = ~ref_clk_in;
    aor_override_regs #(.NUM_PORTS(4'h2), .OVR_INIT(32'hffffffff), .LANE_SEL(3'h3)) DUT (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .cfg_bus_address_in(a), .cfg_bus_read_in(rd),
        .cfg_bus_write_in(wr), .cfg_bus_byte_strobes_in(b), .cfg_bus_write_data_in(d),
        .cfg_bus_read_data_out(q), .cfg_bus_read_valid_out(vl), .cfg_bus_stall_out(st),
        .ability_override_out(ov), .autoneg_lane_select_out(ln));
    aor_host u_host (.c_in(ref_clk_in), .s_in(st), .v_in(vl), .q_in(q), .a_out(a),
        .rd_out(rd), .wr_out(wr), .b_out(b), .d_out(d));
    // compare and count
    task chk(input [31:0] g, e);
        tests_run++;
        error_cnt += (g !== e);
        if (g !== e) $display("BAD %0t got %h want %h", $time, g, e);
    endtask
    // reset values, lane, then each bit alone
    task t_bits;
        chk(ov[63:32], 32'h3ffffe78);
        chk({29'h0, ln}, 32'h3);
        for (i = 0; i < 32; i++)
        begin
            u_host.acc(1'b1, 12'h0cc, 4'hf, 32'h1 << i, r);
            u_host.acc(1'b0, 12'h0cc, 4'hf, 32'h0, r);
            chk(r, (32'h1 << i) & 32'h3ffffe78);
        end
    endtask
    // byte strobes, bad offset, bad port
    task t_bytes;
        u_host.acc(1'b1, 12'h0cc, 4'h2, 32'hffffffff, r);
        chk(ov[31:0], 32'hfe00);
        u_host.acc(1'b1, 12'h3cc, 4'hf, 32'hffffffff, r);
        chk(ov[127:96], 32'h3ffffe78);
        u_host.acc(1'b0, 12'h0d0, 4'hf, 32'h0, r);
        chk(r, 32'h3);
        u_host.acc(1'b0, 12'h0c8, 4'hf, 32'h0, r);
        chk(r, 32'h0);
        u_host.acc(1'b0, 12'h1cc, 4'hf, 32'h0, r);
        chk(r, 32'h3ffffe78);
    endtask
    // verdict
    task wrap_up(input integer bad);
        error_cnt += bad;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // reset, then scenarios
    initial
    begin
        repeat (3) @(posedge ref_clk_in);
        #1 rst_in = 1'b0;
        t_bits;
        t_bytes;
        wrap_up(0);
    end
endmodule // aor_override_regs_bench
